// >>> hcsf_pkg.sv
// ************************************************************
// Status register layout and reset values
// ************************************************************
package hcsf_pkg;

    // Register width
    localparam int unsigned STATUS_W = 8;

    // Field positions inside the channel status byte
    localparam int unsigned OUT_FULL_BIT = 0;
    localparam int unsigned IN_FULL_BIT  = 1;
    localparam int unsigned USER_LO_BIT  = 2;
    localparam int unsigned CD_BIT       = 3;
    localparam int unsigned USER_HI_LSB  = 4;
    localparam int unsigned USER_HI_W    = 4;

    // Values after reset
    localparam logic [7:0] STATUS_RST  = 8'h00;
    localparam logic [3:0] USER_HI_RST = 4'h0;
    localparam logic       FLAG_RST    = 1'b0;

endpackage

// >>> hcsf_status_flags.sv
`timescale 1ns/1ps

// How it works
// RL1: Each host write to the input data register copies host address bit 2 into the command/data flag at bit 3.
// RL2: The command/data flag reads 0 when the last input byte was data.
// RL3: The command/data flag reads 1 when the last input byte was a command.
// RL4: The command/data flag cannot be written by either side and resets to 0.
// RL5: A completed host write to the input data register sets the input-full flag at bit 1.
// RL6: The input-full flag is offered to the local processor as an interrupt request.
// RL7: A local read of the input data register clears the input-full flag.
// RL8: The input-full flag cannot be written by either side and resets to 0.
// RL9: With the fast gate function active, the input-full flag follows that function's own set and clear events.
// RL10: A local write of the output data register sets the output-full flag at bit 0.
// RL11: A host read of the output data register clears the output-full flag.
// RL12: A local write of 0 to the output-full bit also clears it.
// RL13: The output-full flag resets to 0, the local side can only clear it and the host can only read it.
// RL14: Bits 7 to 4 are user bits, reset to 0, read and written locally, read-only to the host.
// RL15: Bit 2 is a user bit, reset to 0, read and written locally, read-only to the host.
// RL16: The whole status byte is all zeros after reset.
// RL17: When a set and a clear of one flag meet in the same cycle, the set wins.
module hcsf_status_flags
    import hcsf_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                host_in_wr,
    input  wire logic                host_addr_bit2,
    input  wire logic                host_out_rd,
    input  wire logic                slave_in_rd,
    input  wire logic                slave_out_wr,
    input  wire logic                slave_status_wr,
    input  wire logic [STATUS_W-1:0] slave_wr_data,
    input  wire logic                fast_gate_active,
    input  wire logic                fast_gate_full_set,
    input  wire logic                fast_gate_full_clr,
    output logic      [STATUS_W-1:0] host_channel_one_status,
    output logic                     input_full_irq
);

    // ************************************************************
    // Flag storage
    // ************************************************************

    logic                 cmd_data_flag_r;
    logic                 input_full_flag_r;
    logic                 output_full_flag_r;
    logic                 user_bit_two_r;
    logic [USER_HI_W-1:0] user_hi_r;

    // ************************************************************
    // Event decode
    // ************************************************************

    logic in_full_set;
    logic in_full_clr;
    logic out_full_set;
    logic out_full_clr;

    // Fast gate mode swaps in its own set and clear sources
    assign in_full_set = fast_gate_active ? fast_gate_full_set : host_in_wr;   // RL9
    assign in_full_clr = fast_gate_active ? fast_gate_full_clr : slave_in_rd;  // RL9

    // Writing 1 to the output-full bit does nothing; only 0 clears
    assign out_full_set = slave_out_wr;
    assign out_full_clr = host_out_rd
                        | (slave_status_wr & ~slave_wr_data[OUT_FULL_BIT]);

    // ************************************************************
    // Command/data flag
    // ************************************************************

    // Captured on every host input write, never by a status write
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_data_flag_r <= FLAG_RST;                 // RL4
        end
        else if (host_in_wr)
        begin
            cmd_data_flag_r <= host_addr_bit2;           // RL1 RL2 RL3
        end
    end

    // ************************************************************
    // Input-full flag
    // ************************************************************

    // Set is tested first so a set event never loses to a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            input_full_flag_r <= FLAG_RST;               // RL8
        end
        else if (in_full_set)
        begin
            input_full_flag_r <= 1'b1;                   // RL5 RL17
        end
        else if (in_full_clr)
        begin
            input_full_flag_r <= 1'b0;                   // RL7
        end
    end

    // ************************************************************
    // Output-full flag
    // ************************************************************

    // Set wins over host read and over a local clearing write
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            output_full_flag_r <= FLAG_RST;              // RL13
        end
        else if (out_full_set)
        begin
            output_full_flag_r <= 1'b1;                  // RL10 RL17
        end
        else if (out_full_clr)
        begin
            output_full_flag_r <= 1'b0;                  // RL11 RL12
        end
    end

    // ************************************************************
    // User bits
    // ************************************************************

    // Host has no write path here, so these are read-only to it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            user_hi_r      <= USER_HI_RST;               // RL14
            user_bit_two_r <= FLAG_RST;                  // RL15
        end
        else if (slave_status_wr)
        begin
            user_hi_r      <= slave_wr_data[USER_HI_LSB +: USER_HI_W]; // RL14
            user_bit_two_r <= slave_wr_data[USER_LO_BIT];              // RL15
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Every bit is a flop, so host and local reads see the same byte
    assign host_channel_one_status = {user_hi_r,
                                      cmd_data_flag_r,
                                      user_bit_two_r,
                                      input_full_flag_r,
                                      output_full_flag_r};   // RL16

    // Interrupt request is the input-full flop itself
    assign input_full_irq = input_full_flag_r;           // RL6

    // ************************************************************
    // Checks
    // ************************************************************

    property p_cd_capture;
        @(posedge clk) disable iff (!arst_n)
        host_in_wr |=> host_channel_one_status[CD_BIT] == $past(host_addr_bit2);
    endproperty
    a_cd_capture: assert property (p_cd_capture) // RL1
        else $error("command/data flag did not take address bit 2");

    property p_cd_data;
        @(posedge clk) disable iff (!arst_n)
        (host_in_wr && !host_addr_bit2) ##1 !host_in_wr[*2]
            |-> !host_channel_one_status[CD_BIT];
    endproperty
    a_cd_data: assert property (p_cd_data) // RL2
        else $error("command/data flag not 0 after data write");

    property p_cd_cmd;
        @(posedge clk) disable iff (!arst_n)
        host_in_wr && host_addr_bit2 |=> host_channel_one_status[CD_BIT];
    endproperty
    a_cd_cmd: assert property (p_cd_cmd) // RL3
        else $error("command/data flag not 1 after command write");

    property p_cd_hold;
        @(posedge clk) disable iff (!arst_n)
        !host_in_wr |=> $stable(host_channel_one_status[CD_BIT]);
    endproperty
    a_cd_hold: assert property (p_cd_hold) // RL4
        else $error("command/data flag changed without a host write");

    property p_in_full_set;
        @(posedge clk) disable iff (!arst_n)
        in_full_set |=> host_channel_one_status[IN_FULL_BIT] && input_full_irq;
    endproperty
    a_in_full_set: assert property (p_in_full_set) // RL5
        else $error("input-full flag not set");

    property p_irq_follow;
        @(posedge clk) disable iff (!arst_n)
        input_full_irq == host_channel_one_status[IN_FULL_BIT];
    endproperty
    a_irq_follow: assert property (p_irq_follow) // RL6
        else $error("interrupt request differs from input-full flag");

    property p_in_full_clr;
        @(posedge clk) disable iff (!arst_n)
        !fast_gate_active && slave_in_rd && !host_in_wr
            |=> !host_channel_one_status[IN_FULL_BIT];
    endproperty
    a_in_full_clr: assert property (p_in_full_clr) // RL7
        else $error("input-full flag not cleared by local read");

    property p_in_full_hold;
        @(posedge clk) disable iff (!arst_n)
        !in_full_set && !in_full_clr |=> $stable(host_channel_one_status[IN_FULL_BIT]);
    endproperty
    a_in_full_hold: assert property (p_in_full_hold) // RL8
        else $error("input-full flag changed without an event");

    property p_in_full_no_wr;
        @(posedge clk) disable iff (!arst_n)
        slave_status_wr && !in_full_set && !in_full_clr
            |=> $stable(host_channel_one_status[IN_FULL_BIT]);
    endproperty
    a_in_full_no_wr: assert property (p_in_full_no_wr) // RL8
        else $error("status write changed input-full flag");

    property p_fast_gate;
        @(posedge clk) disable iff (!arst_n)
        fast_gate_active && host_in_wr && !fast_gate_full_set
            && !host_channel_one_status[IN_FULL_BIT]
            |=> !host_channel_one_status[IN_FULL_BIT];
    endproperty
    a_fast_gate: assert property (p_fast_gate) // RL9
        else $error("ordinary set used while fast gate active");

    property p_in_full_fast_clr;
        @(posedge clk) disable iff (!arst_n)
        fast_gate_active && fast_gate_full_clr && !fast_gate_full_set
            |=> !host_channel_one_status[IN_FULL_BIT];
    endproperty
    a_in_full_fast_clr: assert property (p_in_full_fast_clr) // RL9
        else $error("fast gate clear did not empty input-full flag");

    property p_out_full_set;
        @(posedge clk) disable iff (!arst_n)
        slave_out_wr |=> host_channel_one_status[OUT_FULL_BIT];
    endproperty
    a_out_full_set: assert property (p_out_full_set) // RL10
        else $error("output-full flag not set by local write");

    property p_out_full_host_clr;
        @(posedge clk) disable iff (!arst_n)
        host_out_rd && !slave_out_wr |=> !host_channel_one_status[OUT_FULL_BIT];
    endproperty
    a_out_full_host_clr: assert property (p_out_full_host_clr) // RL11
        else $error("output-full flag not cleared by host read");

    property p_out_full_zero_wr;
        @(posedge clk) disable iff (!arst_n)
        slave_status_wr && !slave_wr_data[OUT_FULL_BIT] && !slave_out_wr
            |=> !host_channel_one_status[OUT_FULL_BIT];
    endproperty
    a_out_full_zero_wr: assert property (p_out_full_zero_wr) // RL12
        else $error("output-full flag not cleared by writing 0");

    property p_out_full_one_wr;
        @(posedge clk) disable iff (!arst_n)
        !slave_out_wr && !host_channel_one_status[OUT_FULL_BIT]
            |=> !host_channel_one_status[OUT_FULL_BIT];
    endproperty
    a_out_full_one_wr: assert property (p_out_full_one_wr) // RL13
        else $error("output-full flag set by other than output write");

    property p_user_hi;
        @(posedge clk) disable iff (!arst_n)
        slave_status_wr |=> host_channel_one_status[USER_HI_LSB +: USER_HI_W]
            == $past(slave_wr_data[USER_HI_LSB +: USER_HI_W]);
    endproperty
    a_user_hi: assert property (p_user_hi) // RL14
        else $error("user bits 7 to 4 not written");

    property p_user_lo;
        @(posedge clk) disable iff (!arst_n)
        !slave_status_wr |=> $stable(host_channel_one_status[USER_LO_BIT])
            && $stable(host_channel_one_status[USER_HI_LSB +: USER_HI_W]);
    endproperty
    a_user_lo: assert property (p_user_lo) // RL15
        else $error("user bits changed without a local write");

    property p_reset_zero;
        @(posedge clk)
        !arst_n |-> host_channel_one_status == STATUS_RST;
    endproperty
    a_reset_zero: assert property (p_reset_zero) // RL16
        else $error("status byte not zero in reset");

    property p_set_wins;
        @(posedge clk) disable iff (!arst_n)
        in_full_set && in_full_clr |=> host_channel_one_status[IN_FULL_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins) // RL17
        else $error("clear beat set on input-full flag");

    property p_out_full_set_wins;
        @(posedge clk) disable iff (!arst_n)
        out_full_set && out_full_clr |=> host_channel_one_status[OUT_FULL_BIT];
    endproperty
    a_out_full_set_wins: assert property (p_out_full_set_wins) // RL17
        else $error("clear beat set on output-full flag");

endmodule

// >>> hcsf_host_model.sv
`timescale 1ns/1ps

// ************************************************************
// Host side: completed I/O cycles seen as one-cycle strobes
// ************************************************************
module hcsf_host_model
(
    input  wire logic clk,
    output logic      host_in_wr,
    output logic      host_addr_bit2,
    output logic      host_out_rd
);

    // Idle at time zero, no cycle in flight
    initial
    begin
        host_in_wr     = 1'b0;
        host_addr_bit2 = 1'b0;
        host_out_rd    = 1'b0;
    end

    // One host cycle; the address line is inverted once released so stale values never pass
    task automatic io_cycle(input logic wr, input logic a2, input logic rd);
        @(posedge clk);
        host_in_wr     <= wr;
        host_addr_bit2 <= a2;
        host_out_rd    <= rd;
        @(posedge clk);
        host_in_wr     <= 1'b0;
        host_addr_bit2 <= ~a2;
        host_out_rd    <= 1'b0;
    endtask

endmodule

// >>> testbench.sv
`timescale 1ns/1ps

// ************************************************************
// Bench for the channel status flags
// ************************************************************
module testbench;
    import hcsf_pkg::*;

    logic                clk;
    logic                arst_n;
    logic                host_in_wr;
    logic                host_addr_bit2;
    logic                host_out_rd;
    logic                slave_in_rd;
    logic                slave_out_wr;
    logic                slave_status_wr;
    logic [STATUS_W-1:0] slave_wr_data;
    logic                fast_gate_active;
    logic                fast_gate_full_set;
    logic                fast_gate_full_clr;
    logic [STATUS_W-1:0] status;
    logic                irq;
    int                  miscompares;
    int                  compares;

    hcsf_status_flags dut (.clk(clk), .arst_n(arst_n), .host_in_wr(host_in_wr), .host_addr_bit2(host_addr_bit2),
        .host_out_rd(host_out_rd), .slave_in_rd(slave_in_rd), .slave_out_wr(slave_out_wr),
        .slave_status_wr(slave_status_wr), .slave_wr_data(slave_wr_data), .fast_gate_active(fast_gate_active),
        .fast_gate_full_set(fast_gate_full_set), .fast_gate_full_clr(fast_gate_full_clr),
        .host_channel_one_status(status), .input_full_irq(irq));

    hcsf_host_model host (.clk(clk), .host_in_wr(host_in_wr), .host_addr_bit2(host_addr_bit2),
        .host_out_rd(host_out_rd));

    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Compare status byte and the interrupt, which must mirror the input-full bit
    task automatic chk(input logic [7:0] exp);
        compares += 2;
        if (status !== exp)
        begin
            miscompares++;
            $display("ERROR status expected %h seen %h", exp, status);
        end
        if (irq !== exp[IN_FULL_BIT])
        begin
            miscompares++;
            $display("ERROR irq expected %b seen %b", exp[IN_FULL_BIT], irq);
        end
    endtask

    // One event cycle: host strobes and local strobes {fs,fc,in_rd,out_wr,status_wr} share an edge
    task automatic step(input logic hw, input logic a2, input logic hr, input logic [4:0] loc,
                        input logic [7:0] d, input logic [7:0] exp);
        fork
            host.io_cycle(hw, a2, hr);
            begin
                @(posedge clk);
                {fast_gate_full_set, fast_gate_full_clr, slave_in_rd, slave_out_wr, slave_status_wr} <= loc;
                slave_wr_data <= d;
                @(posedge clk);
                {fast_gate_full_set, fast_gate_full_clr, slave_in_rd, slave_out_wr, slave_status_wr} <= 5'h00;
                slave_wr_data <= ~d;
            end
        join
        #1;
        chk(exp);
    endtask

    // Verdict; also reached by the watchdog
    task automatic stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog: the sequence needs well under 100 cycles
    initial
    begin
        #20000;
        miscompares++;
        stop_test();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        miscompares = 0;
        compares = 0;
        arst_n = 1'b0;
        {slave_in_rd, slave_out_wr, slave_status_wr, fast_gate_active} = 4'h0;
        {fast_gate_full_set, fast_gate_full_clr} = 2'h0;
        slave_wr_data = 8'h00;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk(STATUS_RST);
        step(1'b1, 1'b1, 1'b0, 5'h00, 8'h00, 8'h0A);
        step(1'b0, 1'b0, 1'b0, 5'h04, 8'h00, 8'h08);
        step(1'b1, 1'b0, 1'b0, 5'h00, 8'h00, 8'h02);
        step(1'b0, 1'b0, 1'b0, 5'h04, 8'h00, 8'h00);
        step(1'b0, 1'b0, 1'b0, 5'h02, 8'h00, 8'h01);
        step(1'b0, 1'b0, 1'b1, 5'h00, 8'h00, 8'h00);
        step(1'b0, 1'b0, 1'b0, 5'h02, 8'h00, 8'h01);
        step(1'b0, 1'b0, 1'b0, 5'h01, 8'hFF, 8'hF5);
        step(1'b0, 1'b0, 1'b0, 5'h01, 8'hF4, 8'hF4);
        step(1'b0, 1'b0, 1'b0, 5'h01, 8'h00, 8'h00);
        step(1'b0, 1'b0, 1'b0, 5'h01, 8'h0B, 8'h00);
        step(1'b1, 1'b0, 1'b0, 5'h06, 8'h00, 8'h03);
        step(1'b0, 1'b0, 1'b1, 5'h03, 8'h00, 8'h03);
        step(1'b0, 1'b0, 1'b1, 5'h04, 8'h00, 8'h00);
        // Fast gate mode swaps the input-full sources; the cmd/data capture stays
        @(posedge clk);
        fast_gate_active <= 1'b1;
        step(1'b1, 1'b1, 1'b0, 5'h00, 8'h00, 8'h08);
        step(1'b0, 1'b0, 1'b0, 5'h10, 8'h00, 8'h0A);
        step(1'b0, 1'b0, 1'b0, 5'h04, 8'h00, 8'h0A);
        step(1'b0, 1'b0, 1'b0, 5'h08, 8'h00, 8'h08);
        step(1'b0, 1'b0, 1'b0, 5'h19, 8'hF0, 8'hFA);
        // Second reset in mid run clears every bit
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(STATUS_RST);
        // Release again; bits stay clear and the first event after release still lands
        @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk(STATUS_RST);
        step(1'b0, 1'b0, 1'b0, 5'h02, 8'h00, 8'h01);
        stop_test();
    end

endmodule
